// ### logic/gcbc_pkg.sv
// Purpose: shared constants of the circulation-box gas board controller
// Assumes: one 50 MHz clock, 16-bit command words, 8-bit read addresses
// Notes: no process here, definitions only
`default_nettype none

package gcbc_pkg;
  // clock and timer step
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int TICK_STEP_MS = 10;
  // cycles per 10 ms step, exact at 50 MHz
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_STEP_MS;
  // intended opening range, in ms
  localparam int OPEN_MIN_MS = 10;
  localparam int OPEN_MAX_MS = 30000;

  // register widths
  localparam int SUPPLY_W = 6;
  localparam int DURATION_W = 12;
  localparam int PUMPV_W = 2;
  localparam int STRAW_W = 2;
  localparam int STATUS_W = 12;
  localparam int NUM_VALVES = 4;

  // command top nibble codes
  localparam logic [3:0] NIB_SUPPLY = 4'h1;
  localparam logic [3:0] NIB_DURATION = 4'h2;
  localparam logic [3:0] NIB_PUMPV = 4'h3;
  localparam logic [3:0] NIB_STRAW = 4'h4;
  localparam logic [3:0] NIB_ACTION = 4'he;
  // middle nibbles that must be zero for nibble 3 and 4 writes
  localparam logic [7:0] SMALL_PAD = 8'h00;

  // action command words
  localparam logic [15:0] CMD_OPEN_FA = 16'he001;
  localparam logic [15:0] CMD_OPEN_FB = 16'he002;
  localparam logic [15:0] CMD_OPEN_SA = 16'he004;
  localparam logic [15:0] CMD_OPEN_SB = 16'he008;
  localparam logic [15:0] CMD_OPEN_PAIR_A = 16'he010;
  localparam logic [15:0] CMD_OPEN_PAIR_B = 16'he020;
  localparam logic [15:0] CMD_FLIP_A_OPEN = 16'he040;
  localparam logic [15:0] CMD_FLIP_B_OPEN = 16'he080;
  localparam logic [15:0] CMD_FLIP_B_CLOSE = 16'he100;
  localparam logic [15:0] CMD_HV_SAFE = 16'he200;

  // valve masks, bit0 first_a, bit1 first_b, bit2 second_a, bit3 second_b
  localparam logic [3:0] VMASK_PAIR_A = 4'h5;
  localparam logic [3:0] VMASK_PAIR_B = 4'ha;

  // read addresses
  localparam logic [7:0] ADDR_LIVE = 8'h01;
  localparam logic [7:0] ADDR_HISTORY = 8'h02;
  localparam logic [7:0] ADDR_SUPPLY = 8'h03;
  localparam logic [7:0] ADDR_DURATION = 8'h04;
  localparam logic [7:0] ADDR_PUMPV = 8'h05;
  localparam logic [7:0] ADDR_STRAW = 8'h06;

  // status word field positions
  localparam int ST_MECH_LSB = 0;
  localparam int ST_VCUR_LSB = 4;
  localparam int ST_PCUR_LSB = 8;
  localparam int ST_PVOLT_LSB = 10;
  // supply mask positions
  localparam int SUP_PUMP_TWO = 4;
  localparam int SUP_PUMP_ONE = 5;

  // reset values
  localparam logic [SUPPLY_W-1:0] SUPPLY_RST = 6'h00;
  localparam logic [DURATION_W-1:0] DURATION_RST = 12'h000;
  localparam logic [PUMPV_W-1:0] PUMPV_RST = 2'h0;
  localparam logic [STRAW_W-1:0] STRAW_RST = 2'h0;
  localparam logic [15:0] RDATA_RST = 16'h0000;
endpackage

`default_nettype wire

// ### logic/gcbc_tick_gen.sv
// Purpose: one-cycle enable pulse every timer step
// Assumes: single clock, async active-high reset
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/1ns
`default_nettype none

module gcbc_tick_gen #(
  parameter int TICK_CYCLES = gcbc_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  // wide enough for the documented 500000-cycle period
  logic [23:0] count;
  logic [23:0] next_count;
  logic next_tick;
  localparam logic [23:0] LAST = 24'(TICK_CYCLES - 1);

  // wrap at the last cycle and pulse once
  always_comb
  begin
    next_tick = (count == LAST);
    next_count = next_tick ? 24'h000000 : count + 24'h000001;
  end

  // register only
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count <= 24'h000000;
      tick_out <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick_out <= next_tick;
    end
  end
endmodule // gcbc_tick_gen

`default_nettype wire

// ### logic/gcbc_event_latch.sv
// Purpose: sticky history bits set on rising edge of each status bit
// Assumes: level inputs already synchronised to clk_in
// Notes: a set in the clearing cycle survives the clear
`timescale 1ns/1ns
`default_nettype none

module gcbc_event_latch #(
  parameter int WIDTH = gcbc_pkg::STATUS_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] level_in,
  input wire logic clear_in,
  output logic [WIDTH-1:0] flags_out
);
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_flags;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        next_flags[i] = (flags_out[i] & ~clear_in) | (level_in[i] & ~prev[i]);
      end
    end
  endgenerate

  // register only; prev starts low so a high level at reset counts
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prev <= '0;
      flags_out <= '0;
    end
    else
    begin
      prev <= level_in;
      flags_out <= next_flags;
    end
  end
endmodule // gcbc_event_latch

`default_nettype wire

// ### logic/gcbc_controller.sv
// Purpose: command decoder and valve/pump control of the circulation box
// Assumes: host bus is synchronous to clk_in; sensor pins are not
// Notes: registers reached by write word and read address only
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - nibble 1 write loads 6-bit supply mask
// - mask bits: valves 0-3, pump two 4, one 5
// - open ignored when valve supply bit zero
// - nibble 2 write loads shared 12-bit duration
// - each duration count is 10 ms
// - zero duration refuses any valve open
// - every valve open command clears the duration
// - duration serves only the four solenoid valves
// - intended range 10 to 30000 ms
// - flipper opens e040/e080, b close e100
// - e200 asserts high-voltage safety output
// - nibble 3 sets pump voltage, 1=12V
// - nibble 4 sets readable analyser select
// - read addresses 1 to 6 return registers
// - status bits 0-3 mechanical, 4-7 energized
// - bits 8-9 pump energized, 10-11 voltage
// - pumps use same connect and status scheme
// - pressure out of range raises close-all
// - history bit latches on open transition
// - reading history clears it
// - energized bit follows coil current comparator
// - supply switch plus timed energize switch
module gcbc_controller #(
  // cycles per 10 ms step; shorten for simulation
  parameter int TICK_CYCLES = gcbc_pkg::TICK_CYCLES,
  // 0: e020 opens valve pair b; 1: e020 closes flipper valve a
  parameter bit PAIR_B_IS_FLIP_CLOSE = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // host write: one command word per strobe cycle
  input wire logic wr_strobe_in,
  input wire logic [15:0] wr_data_in,
  // host read: address taken on strobe, data one cycle later
  input wire logic rd_strobe_in,
  input wire logic [7:0] rd_addr_in,
  output logic [15:0] rd_data_out,
  // sensor pins, asynchronous to clk_in
  input wire logic [3:0] valve_mechanical_flag_in,
  input wire logic [3:0] valve_energized_flag_in,
  input wire logic [1:0] pump_energized_flag_in,
  input wire logic [2:0] box_pressure_high_in,
  input wire logic [2:0] box_pressure_low_in,
  // actuators
  output logic [5:0] supply_connect_out,
  output logic [3:0] valve_energize_out,
  output logic [1:0] pump_voltage_flag_out,
  output logic [1:0] straw_tube_select_out,
  output logic flipper_valve_a_open_out,
  output logic flipper_valve_a_close_out,
  output logic flipper_valve_b_open_out,
  output logic flipper_valve_b_close_out,
  output logic hv_safety_out,
  output logic close_all_out
);
  localparam int NV = gcbc_pkg::NUM_VALVES;
  localparam int DW = gcbc_pkg::DURATION_W;
  localparam logic [DW-1:0] DURATION_ZERO = gcbc_pkg::DURATION_RST;

  // pin synchroniser, 16 bits wide
  logic [15:0] pins_raw;
  logic [15:0] sync_a;
  logic [15:0] sync_b;
  // synchronised pin groups
  logic [3:0] mech_s;
  logic [3:0] vcur_s;
  logic [1:0] pcur_s;
  logic [2:0] phigh_s;
  logic [2:0] plow_s;

  // software registers
  logic [gcbc_pkg::SUPPLY_W-1:0] supply_connect_mask;
  logic [DW-1:0] valve_open_duration;
  logic [gcbc_pkg::PUMPV_W-1:0] pump_voltage_select;
  logic [gcbc_pkg::STRAW_W-1:0] straw_tube_select;
  logic [gcbc_pkg::SUPPLY_W-1:0] next_supply;
  logic [DW-1:0] next_duration;
  logic [gcbc_pkg::PUMPV_W-1:0] next_pumpv;
  logic [gcbc_pkg::STRAW_W-1:0] next_straw;

  // decoded command
  logic [3:0] nib;
  logic [3:0] open_req;
  logic [3:0] open_fire;
  logic flip_a_open_cmd;
  logic flip_a_close_cmd;
  logic flip_b_open_cmd;
  logic flip_b_close_cmd;
  logic hv_cmd;

  // action outputs next values
  logic next_fa_open;
  logic next_fa_close;
  logic next_fb_open;
  logic next_fb_close;
  logic next_hv;
  logic next_close_all;

  // timers and status
  logic tick;
  logic [DW-1:0] valve_timer [NV];
  logic [DW-1:0] next_timer [NV];
  logic [NV-1:0] next_energize;
  logic [gcbc_pkg::STATUS_W-1:0] valve_pump_live_state;
  logic [gcbc_pkg::STATUS_W-1:0] valve_pump_history;
  logic history_clear;
  logic [15:0] next_rd_data;

  // 10 ms step enable
  // 10 ms step
  gcbc_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  // gather every asynchronous pin into one vector
  assign pins_raw = {box_pressure_low_in, box_pressure_high_in,
    pump_energized_flag_in, valve_energized_flag_in,
    valve_mechanical_flag_in};

  // two flops; only sync_b is read by logic
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync_a <= 16'h0000;
      sync_b <= 16'h0000;
    end
    else
    begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
    end
  end

  assign mech_s = sync_b[3:0];
  assign vcur_s = sync_b[7:4];
  assign pcur_s = sync_b[9:8];
  assign phigh_s = sync_b[12:10];
  assign plow_s = sync_b[15:13];

  // command decode from the write strobe and word; open_fire also needs supply and a nonzero duration
  always_comb
  begin
    nib = wr_data_in[15:12];
    open_req = 4'h0;
    flip_a_open_cmd = 1'b0;
    flip_a_close_cmd = 1'b0;
    flip_b_open_cmd = 1'b0;
    flip_b_close_cmd = 1'b0;
    hv_cmd = 1'b0;
    if (wr_strobe_in)
    begin
      case (wr_data_in)
        gcbc_pkg::CMD_OPEN_FA: open_req = 4'h1;
        gcbc_pkg::CMD_OPEN_FB: open_req = 4'h2;
        gcbc_pkg::CMD_OPEN_SA: open_req = 4'h4;
        gcbc_pkg::CMD_OPEN_SB: open_req = 4'h8;
        gcbc_pkg::CMD_OPEN_PAIR_A: open_req = gcbc_pkg::VMASK_PAIR_A;
        gcbc_pkg::CMD_OPEN_PAIR_B:
        begin
          if (PAIR_B_IS_FLIP_CLOSE)
            flip_a_close_cmd = 1'b1;
          else
            open_req = gcbc_pkg::VMASK_PAIR_B;
        end
        gcbc_pkg::CMD_FLIP_A_OPEN: flip_a_open_cmd = 1'b1;
        gcbc_pkg::CMD_FLIP_B_OPEN: flip_b_open_cmd = 1'b1;
        gcbc_pkg::CMD_FLIP_B_CLOSE: flip_b_close_cmd = 1'b1;
        gcbc_pkg::CMD_HV_SAFE: hv_cmd = 1'b1;
        default: open_req = 4'h0;
      endcase
    end
    open_fire = open_req & supply_connect_mask[3:0]
      & {4{valve_open_duration != DURATION_ZERO}};
  end

  // register writes; nibbles 3 and 4 need a zero middle byte
  always_comb
  begin
    next_supply = supply_connect_mask;
    next_duration = valve_open_duration;
    next_pumpv = pump_voltage_select;
    next_straw = straw_tube_select;
    if (wr_strobe_in)
    begin
      case (nib)
        gcbc_pkg::NIB_SUPPLY:
          next_supply = wr_data_in[gcbc_pkg::SUPPLY_W-1:0];
        gcbc_pkg::NIB_DURATION:
          next_duration = wr_data_in[DW-1:0];
        gcbc_pkg::NIB_PUMPV:
        begin
          if (wr_data_in[11:4] == gcbc_pkg::SMALL_PAD)
            next_pumpv = wr_data_in[gcbc_pkg::PUMPV_W-1:0];
        end
        gcbc_pkg::NIB_STRAW:
        begin
          if (wr_data_in[11:4] == gcbc_pkg::SMALL_PAD)
            next_straw = wr_data_in[gcbc_pkg::STRAW_W-1:0];
        end
        default: next_supply = supply_connect_mask;
      endcase
    end
    // any open clears duration, even a refused one
    if (|open_req)
      next_duration = DURATION_ZERO;
  end

  // software register storage
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      supply_connect_mask <= gcbc_pkg::SUPPLY_RST;
      valve_open_duration <= gcbc_pkg::DURATION_RST;
      pump_voltage_select <= gcbc_pkg::PUMPV_RST;
      straw_tube_select <= gcbc_pkg::STRAW_RST;
    end
    else
    begin
      supply_connect_mask <= next_supply;
      valve_open_duration <= next_duration;
      pump_voltage_select <= next_pumpv;
      straw_tube_select <= next_straw;
    end
  end

  // one countdown per solenoid valve, all fed from the one duration
  genvar v;
  generate
    for (v = 0; v < NV; v++)
    begin : g_valve
      always_comb
      begin
        next_timer[v] = valve_timer[v];
        if (open_fire[v])
          next_timer[v] = valve_open_duration;
        else if (tick && (valve_timer[v] != DURATION_ZERO))
          next_timer[v] = valve_timer[v] - 12'h001;
        // losing supply also abandons the opening
        if (!supply_connect_mask[v])
          next_timer[v] = DURATION_ZERO;
        next_energize[v] = (next_timer[v] != DURATION_ZERO);
      end

      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          valve_timer[v] <= gcbc_pkg::DURATION_RST;
          valve_energize_out[v] <= 1'b0;
        end
        else
        begin
          valve_timer[v] <= next_timer[v];
          valve_energize_out[v] <= next_energize[v];
        end
      end
    end
  endgenerate

  // flipper pulses, hv latch and close-all
  always_comb
  begin
    next_fa_open = flip_a_open_cmd;
    next_fa_close = flip_a_close_cmd;
    next_fb_open = flip_b_open_cmd;
    next_fb_close = flip_b_close_cmd;
    // hv safety holds until reset; nothing in the command set releases it
    next_hv = hv_safety_out | hv_cmd;
    next_close_all = (|phigh_s) | (|plow_s);
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flipper_valve_a_open_out <= 1'b0;
      flipper_valve_a_close_out <= 1'b0;
      flipper_valve_b_open_out <= 1'b0;
      flipper_valve_b_close_out <= 1'b0;
      hv_safety_out <= 1'b0;
      close_all_out <= 1'b0;
    end
    else
    begin
      flipper_valve_a_open_out <= next_fa_open;
      flipper_valve_a_close_out <= next_fa_close;
      flipper_valve_b_open_out <= next_fb_open;
      flipper_valve_b_close_out <= next_fb_close;
      hv_safety_out <= next_hv;
      close_all_out <= next_close_all;
    end
  end

  assign supply_connect_out = supply_connect_mask;
  assign pump_voltage_flag_out = pump_voltage_select;
  assign straw_tube_select_out = straw_tube_select;

  assign valve_pump_live_state = {pump_voltage_select[1],
    pump_voltage_select[0], pcur_s[1], pcur_s[0], vcur_s, mech_s};

  assign history_clear = rd_strobe_in
    && (rd_addr_in == gcbc_pkg::ADDR_HISTORY);

  gcbc_event_latch #(
    .WIDTH(gcbc_pkg::STATUS_W)
  ) u_history (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .level_in(valve_pump_live_state),
    .clear_in(history_clear),
    .flags_out(valve_pump_history)
  );

  // read mux; unknown addresses return zero
  always_comb
  begin
    next_rd_data = rd_data_out;
    if (rd_strobe_in)
    begin
      case (rd_addr_in)
        gcbc_pkg::ADDR_LIVE: next_rd_data = {4'h0, valve_pump_live_state};
        gcbc_pkg::ADDR_HISTORY: next_rd_data = {4'h0, valve_pump_history};
        gcbc_pkg::ADDR_SUPPLY: next_rd_data = {10'h000, supply_connect_mask};
        gcbc_pkg::ADDR_DURATION: next_rd_data = {4'h0, valve_open_duration};
        gcbc_pkg::ADDR_PUMPV: next_rd_data = {14'h0000, pump_voltage_select};
        gcbc_pkg::ADDR_STRAW: next_rd_data = {14'h0000, straw_tube_select};
        default: next_rd_data = gcbc_pkg::RDATA_RST;
      endcase
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rd_data_out <= gcbc_pkg::RDATA_RST;
    else
      rd_data_out <= next_rd_data;
  end

  // intended range fits the counter
  // note: 4095 steps reach 40950 ms, above the 30000 ms intended ceiling
endmodule // gcbc_controller

`default_nettype wire

// ### verif/gcbc_controller_monitor.sv
// Purpose: port-level checks of the circulation box controller
// Assumes: bound to gcbc_controller, single clock domain
// Notes: history and live status words are judged by the bench
`timescale 1ns/1ns
`default_nettype none

module gcbc_controller_monitor #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_strobe_in,
  input wire logic [15:0] wr_data_in,
  input wire logic rd_strobe_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic [15:0] rd_data_out,
  input wire logic [2:0] box_pressure_high_in,
  input wire logic [2:0] box_pressure_low_in,
  input wire logic [5:0] supply_connect_out,
  input wire logic [3:0] valve_energize_out,
  input wire logic [1:0] pump_voltage_flag_out,
  input wire logic [1:0] straw_tube_select_out,
  input wire logic flipper_valve_b_open_out,
  input wire logic hv_safety_out,
  input wire logic close_all_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // decoded shorthands of the host word and the pressure pins
  logic [3:0] nib;
  logic bad_p;
  logic open_cmd;
  logic open_a;
  logic [11:0] dur_q;
  logic [11:0] run_q;
  int cnt;
  assign nib = wr_data_in[15:12];
  assign bad_p = |{box_pressure_high_in, box_pressure_low_in};
  assign open_cmd = wr_strobe_in && wr_data_in[15:6] == 10'h380
    && wr_data_in[5:0] != 6'h00;
  assign open_a = open_cmd && supply_connect_out[0] && dur_q != 12'h000
    && (wr_data_in == 16'he001 || wr_data_in == 16'he010);

  // shadow of the duration; a reopen while running would skew cnt
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dur_q <= 12'h000;
      run_q <= 12'h000;
      cnt <= 0;
    end
    else
    begin
      if (wr_strobe_in && nib == gcbc_pkg::NIB_DURATION)
        dur_q <= wr_data_in[11:0];
      else if (open_cmd)
        dur_q <= 12'h000;
      if (open_a)
        run_q <= dur_q;
      cnt <= valve_energize_out[0] ? cnt + 1 : 0;
    end
  end

  AST_SUPPLY_LOAD: assert property (wr_strobe_in && nib == 4'h1
    |=> supply_connect_out == $past(wr_data_in[5:0]))
    else $error("supply mask not loaded");
  AST_SUPPLY_REFUSE: assert property (open_cmd && wr_data_in == 16'he001
    && !supply_connect_out[0] && !valve_energize_out[0]
    |=> !valve_energize_out[0] [*2]) else $error("open without supply");
  AST_ZERO_REFUSE: assert property (open_cmd && dur_q == 12'h000
    && valve_energize_out == 4'h0 |=> valve_energize_out == 4'h0)
    else $error("open with zero duration");
  AST_OPEN_LEN: assert property (
    cnt <= int'(run_q) * TICK_CYCLES + 2) else $error("opening too long");
  AST_OPEN_FALL: assert property ($fell(valve_energize_out[0])
    |-> $past(cnt) + 2 >= (int'(run_q) - 1) * TICK_CYCLES)
    else $error("opening too short");
  AST_OPEN_CAUSE: assert property ($rose(valve_energize_out[0])
    |-> $past(open_a)) else $error("valve energized uncommanded");
  AST_PUMPV_LOAD: assert property (wr_strobe_in && wr_data_in[15:4]
    == 12'h300 |=> pump_voltage_flag_out == $past(wr_data_in[1:0]))
    else $error("pump voltage not loaded");
  AST_STRAW_LOAD: assert property (wr_strobe_in && wr_data_in[15:4]
    == 12'h400 |=> straw_tube_select_out == $past(wr_data_in[1:0]))
    else $error("analyser select not loaded");
  AST_PAD_IGNORE: assert property (wr_strobe_in && nib == 4'h3
    && wr_data_in[11:4] != 8'h00 |=> $stable(pump_voltage_flag_out))
    else $error("padded pump word taken");
  AST_FLIP_B: assert property (wr_strobe_in && wr_data_in == 16'he080
    |-> ##[1:2] flipper_valve_b_open_out) else $error("no flipper pulse");
  AST_HV_SET: assert property (wr_strobe_in && wr_data_in == 16'he200
    |-> ##[1:2] hv_safety_out ##1 hv_safety_out [*3])
    else $error("hv safety not held");
  AST_CLOSE_ALL: assert property (bad_p [*4] |-> close_all_out)
    else $error("close-all missing");
  AST_CLOSE_IDLE: assert property (!bad_p [*4] |-> !close_all_out)
    else $error("close-all spurious");
  AST_RD_SUPPLY: assert property (rd_strobe_in && rd_addr_in == 8'h03
    && !wr_strobe_in |-> ##2 rd_data_out == {10'h000, supply_connect_out})
    else $error("supply readback wrong");
  AST_RD_UNMAPPED: assert property (rd_strobe_in && rd_addr_in > 8'h06
    |-> ##2 rd_data_out == 16'h0000) else $error("unmapped read not zero");

  COV_OPEN: cover property ($rose(valve_energize_out[0]));
  COV_CLOSE_ALL: cover property ($rose(close_all_out));
  COV_HV: cover property ($rose(hv_safety_out));
endmodule // gcbc_controller_monitor

bind gcbc_controller gcbc_controller_monitor #(
  .TICK_CYCLES(TICK_CYCLES)
) i_gcbc_controller_monitor (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .wr_strobe_in(wr_strobe_in),
  .wr_data_in(wr_data_in),
  .rd_strobe_in(rd_strobe_in),
  .rd_addr_in(rd_addr_in),
  .rd_data_out(rd_data_out),
  .box_pressure_high_in(box_pressure_high_in),
  .box_pressure_low_in(box_pressure_low_in),
  .supply_connect_out(supply_connect_out),
  .valve_energize_out(valve_energize_out),
  .pump_voltage_flag_out(pump_voltage_flag_out),
  .straw_tube_select_out(straw_tube_select_out),
  .flipper_valve_b_open_out(flipper_valve_b_open_out),
  .hv_safety_out(hv_safety_out),
  .close_all_out(close_all_out)
);

`default_nettype wire

// ### verif/gcbc_plant_model.sv
// Purpose: valves and pumps seen from the board's sensor pins
// Assumes: coil current flows only with both switches closed
// Notes: slow_in adds a stage, like a sluggish valve
`timescale 1ns/1ns
`default_nettype none

module gcbc_plant_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic [5:0] supply_in,
  input wire logic [3:0] energize_in,
  output logic [3:0] mech_out,
  output logic [3:0] coil_out,
  output logic [1:0] pump_out
);
  // two lag stages of {pump two, pump one, coil current}
  logic [5:0] st1 = 6'h00;
  logic [5:0] st2 = 6'h00;
  // coil current needs supply and energize
  always @(posedge clk_in)
  begin
    st1 <= {supply_in[4], supply_in[5], supply_in[3:0] & energize_in};
    st2 <= st1;
  end
  // flag follows current, 1 means open
  assign coil_out = slow_in ? st2[3:0] : st1[3:0];
  assign mech_out = st2[3:0];
  // bit0 pump one, bit1 pump two
  assign pump_out = {st1[5], st1[4]};
endmodule // gcbc_plant_model

`default_nettype wire

// ### verif/test_gas_circulation_box_controller.sv
// Purpose: self-checking bench of the circulation box controller
// Assumes: short timer step, plant model on the valve and pump sensor pins, pressure pins driven by the bench
// Notes: inputs change 1 ns after the rising clock edge
`timescale 1ns/1ns
`default_nettype none

module test_gas_circulation_box_controller;
  localparam int TICK = 10;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_strobe_in = 1'b0;
  logic [15:0] wr_data_in = 16'h0000;
  logic rd_strobe_in = 1'b0;
  logic [7:0] rd_addr_in = 8'h00;
  logic [15:0] rd_data_out;
  logic [3:0] mech;
  logic [3:0] coil;
  logic [1:0] pump;
  logic [2:0] p_high = 3'h0;
  logic [2:0] p_low = 3'h0;
  logic slow = 1'b0;
  logic [5:0] supply;
  logic [3:0] energize;
  logic [1:0] pumpv;
  logic [1:0] straw;
  wire [3:0] flips;
  logic hv;
  logic close_all;
  int bad_count = 0;
  int checked = 0;

  // free-running 50 MHz clock
  always #10 clk_in = ~clk_in;

  gcbc_controller #(.TICK_CYCLES(TICK)) i_gcbc_controller (
    .clk_in(clk_in), .rst_in(rst_in),
    .wr_strobe_in(wr_strobe_in), .wr_data_in(wr_data_in),
    .rd_strobe_in(rd_strobe_in), .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out),
    .valve_mechanical_flag_in(mech), .valve_energized_flag_in(coil),
    .pump_energized_flag_in(pump),
    .box_pressure_high_in(p_high), .box_pressure_low_in(p_low),
    .supply_connect_out(supply), .valve_energize_out(energize),
    .pump_voltage_flag_out(pumpv), .straw_tube_select_out(straw),
    .flipper_valve_a_open_out(flips[3]),
    .flipper_valve_a_close_out(flips[2]),
    .flipper_valve_b_open_out(flips[1]),
    .flipper_valve_b_close_out(flips[0]),
    .hv_safety_out(hv), .close_all_out(close_all));

  gcbc_plant_model i_gcbc_plant_model (.clk_in(clk_in), .slow_in(slow),
    .supply_in(supply), .energize_in(energize),
    .mech_out(mech), .coil_out(coil), .pump_out(pump));

  task automatic stop_test();
    $display("mismatches %0d of %0d checks", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check16(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      $display("mismatch at %0t got %h expected %h", $time, g, e);
      bad_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // one command word, strobe held for exactly one edge
  task automatic wr(input logic [15:0] w);
    @(posedge clk_in);
    #1;
    wr_strobe_in = 1'b1;
    wr_data_in = w;
    tick(1);
    wr_strobe_in = 1'b0;
  endtask

  // read data taken one edge after the strobe edge
  task automatic rd_check(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_in);
    #1;
    rd_strobe_in = 1'b1;
    rd_addr_in = a;
    tick(1);
    rd_strobe_in = 1'b0;
    tick(1);
    check16(e, rd_data_out);
  endtask

  task automatic s_registers();
    for (int a = 1; a < 8; a++)
      rd_check(a[7:0], 16'h0000);
    wr(16'h103f);
    rd_check(8'h03, 16'h003f);
    check16(16'h003f, {10'h000, supply});
    wr(16'h2abc);
    rd_check(8'h04, 16'h0abc);
    wr(16'h3002);
    rd_check(8'h05, 16'h0002);
    wr(16'h4003);
    rd_check(8'h06, 16'h0003);
    check16(16'h0003, {14'h0000, straw});
    // padded and unknown words must leave everything alone
    wr(16'h3012);
    wr(16'h4100);
    wr(16'h5123);
    wr(16'he400);
    rd_check(8'h05, 16'h0002);
    rd_check(8'h06, 16'h0003);
    rd_check(8'h04, 16'h0abc);
    rd_check(8'hff, 16'h0000);
  endtask

  task automatic s_open();
    int n;
    rd_check(8'h02, 16'h0b00);
    wr(16'h2003);
    wr(16'he001);
    check16(16'h0001, {12'h000, energize});
    n = 0;
    fork
      while (energize[0] === 1'b1 && n < 100)
      begin
        tick(1);
        n++;
      end
      begin
        rd_check(8'h04, 16'h0000);
        tick(2);
        rd_check(8'h01, 16'h0b11);
      end
    join
    check16(16'h0001, {15'h0000, n >= 2 * TICK && n <= 3 * TICK + 1});
    tick(8);
    rd_check(8'h01, 16'h0b00);
    rd_check(8'h02, 16'h0011);
    rd_check(8'h02, 16'h0000);
  endtask

  task automatic s_refuse();
    wr(16'h103e);
    wr(16'h2005);
    wr(16'he001);
    tick(2);
    check16(16'h0000, {12'h000, energize});
    rd_check(8'h04, 16'h0000);
    wr(16'h103f);
    wr(16'he001);
    tick(2);
    check16(16'h0000, {12'h000, energize});
  endtask

  task automatic s_table();
    logic [15:0] cmds [5] = '{16'he002, 16'he004, 16'he008,
      16'he010, 16'he020};
    logic [3:0] masks [5] = '{4'h2, 4'h4, 4'h8, 4'h5, 4'ha};
    slow = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wr(16'h2002);
      wr(cmds[i]);
      check16({12'h000, masks[i]}, {12'h000, energize});
      for (int k = 0; k < 40 && energize !== 4'h0; k++)
        tick(1);
      check16(16'h0000, {12'h000, energize});
    end
    slow = 1'b0;
    rd_check(8'h02, 16'h00ff);
  endtask

  task automatic s_flip();
    logic [15:0] cmds [3] = '{16'he040, 16'he080, 16'he100};
    logic [3:0] want [3] = '{4'h8, 4'h2, 4'h1};
    logic [3:0] seen;
    for (int i = 0; i < 3; i++)
    begin
      wr(cmds[i]);
      seen = flips;
      repeat (2)
      begin
        tick(1);
        seen = seen | flips;
      end
      check16({12'h000, want[i]}, {12'h000, seen});
    end
    wr(16'he200);
    tick(2);
    check16(16'h0001, {15'h0000, hv});
  endtask

  task automatic s_pressure();
    for (int i = 0; i < 6; i++)
    begin
      {p_high, p_low} = 6'h01 << i;
      tick(5);
      check16(16'h0001, {15'h0000, close_all});
      {p_high, p_low} = 6'h00;
      tick(5);
      check16(16'h0000, {15'h0000, close_all});
    end
  endtask

  task automatic s_second_reset();
    rst_in = 1'b1;
    tick(3);
    rst_in = 1'b0;
    tick(1);
    check16(16'h0000, {9'h000, supply, hv});
    rd_check(8'h04, 16'h0000);
  endtask

  // hang guard, far beyond the expected run length
  initial
  begin
    #400000;
    bad_count++;
    stop_test();
  end

  initial
  begin
    tick(12);
    rst_in = 1'b0;
    s_registers();
    s_open();
    s_refuse();
    s_table();
    s_flip();
    s_pressure();
    s_second_reset();
    stop_test();
  end
endmodule // test_gas_circulation_box_controller

`default_nettype wire
